// [rtl/ddc_front_pkg.sv]
// Purpose: Shared constants and types of the down-converter front end
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Oscillator index k covers both converters: k = converter * 4 + oscillator
package ddc_front_pkg;
	// Widths and counts
	localparam int OSC_PER_DDC  = 4;
	localparam int NUM_DDC      = 2;
	localparam int NUM_OSC      = OSC_PER_DDC * NUM_DDC;
	localparam int SAMPLE_W     = 12;
	localparam int PHASE_W      = 32;
	localparam int OFFSET_W     = 16;
	localparam int TRIG_W       = 16;
	localparam int IQ_W         = 16;
	localparam int PROD_W       = SAMPLE_W + TRIG_W;
	localparam int ROUND_SHIFT  = 11;
	localparam int RDIV_W       = 16;
	localparam int RDIV_SCALE_W = 6;          // Divider counts in units of 64 clocks
	localparam int RCNT_W       = RDIV_W + RDIV_SCALE_W;
	localparam int LUT_ADDR_W   = 6;          // Two quadrant bits and four index bits

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_RDIV    = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_FREQ_A  = 8'h10;
	localparam logic [7:0] ADDR_FREQ_B  = 8'h20;
	localparam logic [7:0] ADDR_PHASE_A = 8'h30;
	localparam logic [7:0] ADDR_PHASE_B = 8'h40;
	localparam logic [7:0] ADDR_LAST    = 8'h4C;

	// Control register fields
	localparam int CTRL_DDC_ENABLE  = 0;
	localparam int CTRL_SINGLE_MODE = 1;
	localparam int CTRL_SEL_SOURCE  = 2;
	localparam int CTRL_SYNC_ILA    = 3;
	localparam int CTRL_SYSREF_ARM  = 4;
	localparam int CTRL_BIND_A      = 5;
	localparam int CTRL_BIND_B      = 6;
	localparam int CTRL_SOFT_SEL_A  = 8;
	localparam int CTRL_SOFT_SEL_B  = 10;
	localparam logic [11:0] CTRL_RESET = 12'h040;  // DDC B bound to channel B

	// Status register fields
	localparam int STAT_ACTIVE_A = 0;
	localparam int STAT_ACTIVE_B = 2;
	localparam int STAT_ARMED    = 4;
	localparam int STAT_SYNCED   = 5;

	// Mixer output pair
	typedef struct packed {
		logic signed [IQ_W-1:0] i;
		logic signed [IQ_W-1:0] q;
	} iq_t;
endpackage

// [rtl/ddc_nco_mixer_front_end.sv]
// Purpose: Bypass or mix raw samples with one of four oscillators per converter
// Assumes: Sample, sync and sysref inputs synchronous to mclk; hop pins asynchronous
// Notes:   APB slave answers with no wait states; filtering follows outside this block
//
// Overview of operation
// RQ1: Samples bypass or enter the down converter
// RQ2: Dual mode: each converter binds to A or B
// RQ3: Single mode: second converter path unavailable
// RQ4: Rounding goes to nearest, ties to even
// RQ5: Full precision kept, round only at output
// RQ6: Mixer multiplies sample by selected complex exponential
// RQ7: Four free-running accumulators per converter
// RQ8: Hop pins switch oscillator without alignment
// RQ9: Source bit picks pins or software select
// RQ10: Zero divider: frequency is word times clock/2^32
// RQ11: Frequency word wraps modulo accumulator width
// RQ12: New frequency word leaves phase undetermined
// RQ13: Nonzero divider lands accumulator on exact steps
// RQ14: Software keeps divider at or below 8192
// RQ15: Phase offset sits in upper half, added
// RQ16: Software triggers sync after frequency changes
// RQ17: Sync from link init or sysref, per settings
// RQ18: Link sync usable whatever the link encoding
// RQ19: Link sync deassertion resynchronises oscillators
// RQ20: Armed sysref rising edge resynchronises oscillators
// RQ21: Hop pins pass a two-flop synchroniser
// RQ22: Sync resets all accumulators together to offsets
`timescale 1ns/10ps
module ddc_nco_mixer_front_end
(
	// Clock and reset
	input  wire logic                                 mclk,
	input  wire logic                                 nrst,
	// APB slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// Converter samples
	input  wire logic [ddc_front_pkg::SAMPLE_W-1:0]   adc_sample_a,
	input  wire logic [ddc_front_pkg::SAMPLE_W-1:0]   adc_sample_b,
	// Hop pins and synchronisation inputs
	input  wire logic                                 hop_pin_a_bit0,
	input  wire logic                                 hop_pin_a_bit1,
	input  wire logic                                 hop_pin_b_bit0,
	input  wire logic                                 hop_pin_b_bit1,
	input  wire logic                                 link_sync_in,
	input  wire logic                                 sysref_in,
	// Outputs toward the serial block
	output logic      [ddc_front_pkg::SAMPLE_W-1:0]   bypass_sample_a,
	output logic      [ddc_front_pkg::SAMPLE_W-1:0]   bypass_sample_b,
	output ddc_front_pkg::iq_t                        mixed_a,
	output ddc_front_pkg::iq_t                        mixed_b,
	output logic                                      mixed_valid_b
);
	localparam int NO = ddc_front_pkg::NUM_OSC;
	localparam int ND = ddc_front_pkg::NUM_DDC;
	localparam int PW = ddc_front_pkg::PHASE_W;

	// Software state
	logic [11:0]                              ctrl;
	logic [ddc_front_pkg::RDIV_W-1:0]         rational_step_divider;
	logic [PW-1:0]                            freq_word   [NO];
	logic [ddc_front_pkg::OFFSET_W-1:0]       phase_off   [NO];
	logic                                     synced_once;

	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic osc_range;
	logic [2:0] osc_idx;
	assign wr_en     = psel && penable && pwrite;
	assign rd_en     = psel && penable && !pwrite;
	assign osc_range = (paddr >= ddc_front_pkg::ADDR_FREQ_A) &&
			(paddr <= ddc_front_pkg::ADDR_LAST) && (paddr[1:0] == 2'h0);
	assign osc_idx   = {~paddr[4], paddr[3:2]};  // Blocks 0x10 and 0x30 belong to converter A
	assign addr_ok   = osc_range || paddr == ddc_front_pkg::ADDR_CTRL ||
			paddr == ddc_front_pkg::ADDR_RDIV || paddr == ddc_front_pkg::ADDR_STATUS;

	// Zero wait states; unmapped words flag an error and read zero
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// Hop pin synchroniser; first stage feeds only the second
	logic [3:0] hop_meta;
	logic [3:0] hop_sync;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			hop_meta <= 4'h0;
			hop_sync <= 4'h0;
		end
		else
		begin
			hop_meta <= {hop_pin_b_bit1, hop_pin_b_bit0, hop_pin_a_bit1, hop_pin_a_bit0}; // [RQ21]
			hop_sync <= hop_meta;                                                       // [RQ21]
		end
	end

	// Edge detection of the link sync and sysref levels
	logic sync_prev;
	logic sysref_prev;
	logic link_rise;
	logic sysref_rise;
	logic sync_evt;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_prev   <= 1'b1;
			sysref_prev <= 1'b0;
		end
		else
		begin
			sync_prev   <= link_sync_in;
			sysref_prev <= sysref_in;
		end
	end
	// Link sync counts regardless of encoding, so 64b/66b links can still align
	assign link_rise   = link_sync_in && !sync_prev;                                  // [RQ18]
	assign sysref_rise = sysref_in && !sysref_prev;
	assign sync_evt    = (link_rise && ctrl[ddc_front_pkg::CTRL_SYNC_ILA]) ||          // [RQ17] [RQ19]
			(sysref_rise && ctrl[ddc_front_pkg::CTRL_SYSREF_ARM]);                     // [RQ20]

	// Control register; the arm bit clears itself once consumed, a write wins
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ctrl <= ddc_front_pkg::CTRL_RESET;
		else if (wr_en && paddr == ddc_front_pkg::ADDR_CTRL)
			ctrl <= pwdata[11:0];
		else if (sysref_rise && ctrl[ddc_front_pkg::CTRL_SYSREF_ARM])
			ctrl[ddc_front_pkg::CTRL_SYSREF_ARM] <= 1'b0;                              // [RQ20]
	end

	// Divider register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rational_step_divider <= 16'h0000;
		else if (wr_en && paddr == ddc_front_pkg::ADDR_RDIV)
			rational_step_divider <= pwdata[15:0];
	end

	// Sticky record that a resync has happened since reset
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			synced_once <= 1'b0;
		else if (sync_evt)
			synced_once <= 1'b1;
	end

	// Oscillator selection, pins or software
	logic [1:0] active_sel [ND];
	assign active_sel[0] = ctrl[ddc_front_pkg::CTRL_SEL_SOURCE] ? hop_sync[1:0] :       // [RQ9] [RQ8]
			ctrl[ddc_front_pkg::CTRL_SOFT_SEL_A +: 2];
	assign active_sel[1] = ctrl[ddc_front_pkg::CTRL_SEL_SOURCE] ? hop_sync[3:2] :       // [RQ9] [RQ8]
			ctrl[ddc_front_pkg::CTRL_SOFT_SEL_B +: 2];

	// Read mux
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_en)
		begin
			case (paddr)
				ddc_front_pkg::ADDR_CTRL:   prdata = {20'h0_0000, ctrl};
				ddc_front_pkg::ADDR_RDIV:   prdata = {16'h0000, rational_step_divider};
				ddc_front_pkg::ADDR_STATUS: prdata = {26'h000_0000, synced_once,
						ctrl[ddc_front_pkg::CTRL_SYSREF_ARM], active_sel[1], active_sel[0]};
				default:
				begin
					if (osc_range && paddr < ddc_front_pkg::ADDR_PHASE_A)
						prdata = freq_word[osc_idx];
					else if (osc_range)
						prdata = {16'h0000, phase_off[osc_idx]};
				end
			endcase
		end
	end

	// Rational divider: after divider*64 clocks every accumulator lands exactly on a whole turn
	logic [ddc_front_pkg::RCNT_W-1:0] rcnt;
	logic [ddc_front_pkg::RCNT_W-1:0] rcnt_last;
	logic                             rwrap;
	assign rcnt_last = {rational_step_divider, 6'h00} - 22'h00_0001;
	assign rwrap     = (rational_step_divider != 16'h0000) && (rcnt == rcnt_last);    // [RQ13]
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rcnt <= 22'h00_0000;
		else if (sync_evt || rwrap || rational_step_divider == 16'h0000)
			rcnt <= 22'h00_0000;
		else
			rcnt <= rcnt + 22'h00_0001;
	end

	// Per-oscillator settings and accumulators
	logic [PW-1:0] acc   [NO];
	logic [PW-1:0] phase [NO];
	for (genvar k = 0; k < NO; k++)
	begin : g_osc
		localparam logic [7:0] FREQ_ADDR  = (k < 4) ? ddc_front_pkg::ADDR_FREQ_A :
				ddc_front_pkg::ADDR_FREQ_B;
		localparam logic [7:0] PHASE_ADDR = (k < 4) ? ddc_front_pkg::ADDR_PHASE_A :
				ddc_front_pkg::ADDR_PHASE_B;
		localparam logic [7:0] SLOT       = 8'((k % 4) * 4);
		// Settings; a running change leaves phase arbitrary until the next sync
		always_ff @(posedge mclk or negedge nrst)
		begin
			if (!nrst)
			begin
				freq_word[k] <= 32'h0000_0000;
				phase_off[k] <= 16'h0000;
			end
			else if (wr_en && paddr == FREQ_ADDR + SLOT)
				freq_word[k] <= pwdata;                                                   // [RQ12]
			else if (wr_en && paddr == PHASE_ADDR + SLOT)
				phase_off[k] <= pwdata[15:0];
		end
		// Always advancing, selected or not, so hops stay phase coherent
		always_ff @(posedge mclk or negedge nrst)
		begin
			if (!nrst)
				acc[k] <= 32'h0000_0000;
			else if (sync_evt || rwrap)
				acc[k] <= 32'h0000_0000;                                                  // [RQ22] [RQ13]
			else
				acc[k] <= acc[k] + freq_word[k];                                          // [RQ7] [RQ10] [RQ11]
		end
		assign phase[k] = acc[k] + {phase_off[k], 16'h0000};                             // [RQ15]
	end

	// Quarter-wave sine table over 17 points; coarse, so spurs are traded for area
	localparam logic [15:0] QUARTER [17] = '{
		16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56, 16'h471C, 16'h5133, 16'h5A82,
		16'h62F1, 16'h6A6D, 16'h70E2, 16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61, 16'h7FFF
	};

	// Coarse sine from the top phase bits, mirrored by quadrant
	function automatic logic signed [15:0] sine(input logic [5:0] p);
		logic [15:0] mag;
		mag = p[4] ? QUARTER[5'h10 - {1'b0, p[3:0]}] : QUARTER[{1'b0, p[3:0]}];
		sine = p[5] ? -$signed(mag) : $signed(mag);
	endfunction

	// Convergent rounding of a full product, then saturation to the output width
	function automatic logic signed [15:0] round_even(input logic signed [27:0] v);
		logic signed [16:0] keep;
		logic        [10:0] frac;
		logic signed [16:0] up;
		keep = v[27:11];
		frac = v[10:0];
		up   = (frac > 11'h400 || (frac == 11'h400 && keep[0])) ? keep + 17'sh0_0001 : keep;
		if (up > 17'sh0_7FFF)
			round_even = 16'h7FFF;
		else if (up < -17'sh0_7FFF)
			round_even = 16'h8001;
		else
			round_even = up[15:0];
	endfunction

	// Per-converter binding, multiply and round
	logic [ddc_front_pkg::SAMPLE_W-1:0] ddc_in  [ND];
	logic signed [27:0]                 prod_i  [ND];
	logic signed [27:0]                 prod_q  [ND];
	ddc_front_pkg::iq_t                 mix_q   [ND];
	logic                               use_ddc [ND];
	assign ddc_in[0]  = ctrl[ddc_front_pkg::CTRL_BIND_A] ? adc_sample_b : adc_sample_a;  // [RQ2]
	assign ddc_in[1]  = ctrl[ddc_front_pkg::CTRL_BIND_B] ? adc_sample_b : adc_sample_a;  // [RQ2]
	assign use_ddc[0] = ctrl[ddc_front_pkg::CTRL_DDC_ENABLE];
	assign use_ddc[1] = ctrl[ddc_front_pkg::CTRL_DDC_ENABLE] &&
			!ctrl[ddc_front_pkg::CTRL_SINGLE_MODE];                                      // [RQ3]
	for (genvar d = 0; d < ND; d++)
	begin : g_ddc
		logic [PW-1:0] sel_phase;
		assign sel_phase = phase[d * 4 + int'(active_sel[d])];
		// Full-width products kept until the single output rounding
		always_ff @(posedge mclk or negedge nrst)
		begin
			if (!nrst)
			begin
				prod_i[d] <= 28'h000_0000;
				prod_q[d] <= 28'h000_0000;
			end
			else
			begin
				prod_i[d] <= $signed(ddc_in[d]) * sine(sel_phase[31:26] + 6'h10);       // [RQ6] [RQ5]
				prod_q[d] <= -($signed(ddc_in[d]) * sine(sel_phase[31:26]));             // [RQ6] [RQ5]
			end
		end
		// Output stage, zero when the path is bypassed or unavailable
		always_ff @(posedge mclk or negedge nrst)
		begin
			if (!nrst)
				mix_q[d] <= '0;
			else if (use_ddc[d])
			begin
				mix_q[d].i <= round_even(prod_i[d]);                                      // [RQ4]
				mix_q[d].q <= round_even(prod_q[d]);                                      // [RQ4]
			end
			else
				mix_q[d] <= '0;
		end
	end
	assign mixed_a       = mix_q[0];
	assign mixed_b       = mix_q[1];
	assign mixed_valid_b = use_ddc[1];

	// Raw path to the serial block while the converters are bypassed
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			bypass_sample_a <= 12'h000;
			bypass_sample_b <= 12'h000;
		end
		else if (!ctrl[ddc_front_pkg::CTRL_DDC_ENABLE])
		begin
			bypass_sample_a <= adc_sample_a;                                              // [RQ1]
			bypass_sample_b <= adc_sample_b;                                              // [RQ1]
		end
		else
		begin
			bypass_sample_a <= 12'h000;
			bypass_sample_b <= 12'h000;
		end
	end
endmodule

// [sim/front_monitor.sv]
// Purpose: Port-level checks of the front end
// Assumes: Sees only the top-level ports
// Notes:   Register state is hidden, so checks tie outputs to inputs
`timescale 1ns/10ps
module front_monitor
(
	// Clock and reset
	input wire logic                               mclk,
	input wire logic                               nrst,
	// APB
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [7:0]                         paddr,
	input wire logic [31:0]                        pwdata,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	// Samples, pins and sync
	input wire logic [ddc_front_pkg::SAMPLE_W-1:0] adc_sample_a,
	input wire logic [ddc_front_pkg::SAMPLE_W-1:0] adc_sample_b,
	input wire logic                               hop_pin_a_bit0,
	input wire logic                               hop_pin_a_bit1,
	input wire logic                               hop_pin_b_bit0,
	input wire logic                               hop_pin_b_bit1,
	input wire logic                               link_sync_in,
	input wire logic                               sysref_in,
	// Outputs
	input wire logic [ddc_front_pkg::SAMPLE_W-1:0] bypass_sample_a,
	input wire logic [ddc_front_pkg::SAMPLE_W-1:0] bypass_sample_b,
	input ddc_front_pkg::iq_t                      mixed_a,
	input ddc_front_pkg::iq_t                      mixed_b,
	input wire logic                               mixed_valid_b
);
	// Single clock domain, so one default for all
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Path B dead long enough for its pipeline to drain
	sequence b_idle3;
		!mixed_valid_b ##1 !mixed_valid_b ##1 !mixed_valid_b;
	endsequence

	// Output side
	AST_BYP_A: assert property (
		bypass_sample_a != 12'h000 |-> bypass_sample_a == $past(adc_sample_a))
		else $error("bypass a not last sample");
	AST_BYP_B: assert property (
		bypass_sample_b != 12'h000 |-> bypass_sample_b == $past(adc_sample_b))
		else $error("bypass b not last sample");
	AST_EXCL_A: assert property (
		bypass_sample_a != 12'h000 && $past(bypass_sample_a) != 12'h000 |-> mixed_a == 32'h0)
		else $error("bypass and mixer both live");
	// Either channel may feed either converter, so both must be zero
	AST_ZERO_A: assert property (
		$past(adc_sample_a, 2) == 12'h000 && $past(adc_sample_b, 2) == 12'h000
		|-> mixed_a == 32'h0)
		else $error("zero sample gave nonzero mix a");
	AST_ZERO_B: assert property (
		$past(adc_sample_b, 2) == 12'h000 && $past(adc_sample_a, 2) == 12'h000
		|-> mixed_b == 32'h0)
		else $error("zero sample gave nonzero mix b");
	AST_B_IDLE: assert property (b_idle3 |-> mixed_b == 32'h0)
		else $error("unused path b not quiet");
	// Bus side
	AST_READY: assert property (pready)
		else $error("pready low");
	AST_RD_IDLE: assert property (!(psel && penable) |-> prdata == 32'h0)
		else $error("read data outside access");
	AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
		else $error("slave error outside access");
	AST_UNMAPPED: assert property (
		psel && penable && paddr > ddc_front_pkg::ADDR_LAST |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule

bind ddc_nco_mixer_front_end front_monitor u_front_monitor
(
	.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.adc_sample_a, .adc_sample_b, .hop_pin_a_bit0, .hop_pin_a_bit1, .hop_pin_b_bit0,
	.hop_pin_b_bit1, .link_sync_in, .sysref_in, .bypass_sample_a, .bypass_sample_b,
	.mixed_a, .mixed_b, .mixed_valid_b
);

// [sim/link_partner.sv]
// Purpose: Link receiver side: drives link sync and sysref
// Assumes: Both lines launched on mclk
// Notes:   Sync held asserted low until told to release
`timescale 1ns/10ps
module link_partner
(
	// Clock, reset and commands
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sync_go,
	input wire logic pulse_go,
	// Lines toward the device
	output logic     link_sync_in,
	output logic     sysref_in
);
	// Sync released high on command, sysref follows the pulse request
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			link_sync_in <= 1'h0;
			sysref_in    <= 1'h0;
		end
		else
		begin
			link_sync_in <= sync_go;
			sysref_in    <= pulse_go;
		end
	end
endmodule

// [sim/tb_top.sv]
// Purpose: Register-driven scenarios for the front end
// Assumes: Zero-wait APB, sample 64 gives mixer magnitude 1024
// Notes:   Phases chosen on quarter turns so results are exact
`timescale 1ns/10ps
module tb_top;
	// Design-facing signals
	logic        mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic        pready, pslverr, err_q, mixed_valid_b, link_sync_in, sysref_in;
	logic        hop_pin_a_bit0 = 1'h0, hop_pin_a_bit1 = 1'h0;
	logic        hop_pin_b_bit0 = 1'h0, hop_pin_b_bit1 = 1'h0, sync_go = 1'h0, pulse_go = 1'h0;
	logic [ddc_front_pkg::SAMPLE_W-1:0] adc_sample_a = 12'h000, adc_sample_b = 12'h000;
	logic [ddc_front_pkg::SAMPLE_W-1:0] bypass_sample_a, bypass_sample_b;
	ddc_front_pkg::iq_t mixed_a, mixed_b;
	int          miscompares = 0, checks_done = 0, cycles = 0;

	// 50 MHz clock
	always #10 mclk = ~mclk;

	ddc_nco_mixer_front_end u_ddc_nco_mixer_front_end
	(
		.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.adc_sample_a, .adc_sample_b, .hop_pin_a_bit0, .hop_pin_a_bit1, .hop_pin_b_bit0,
		.hop_pin_b_bit1, .link_sync_in, .sysref_in, .bypass_sample_a, .bypass_sample_b,
		.mixed_a, .mixed_b, .mixed_valid_b
	);
	link_partner u_link_partner
	(
		.mclk, .nrst, .sync_go, .pulse_go, .link_sync_in, .sysref_in
	);

	// One transfer; first edge keeps psel from being set twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
			@(posedge mclk);
		while (pready !== 1'h1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, far above the roughly 180 cycles needed
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			report_and_stop;
		end
	end

	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'h1;
		rd(ddc_front_pkg::ADDR_CTRL, 32'h40);
		rd(ddc_front_pkg::ADDR_STATUS, 32'h0);
		rd(8'h50, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		adc_sample_a <= 12'h040;
		adc_sample_b <= 12'h123;
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h40);
		cyc(3);
		chk(bypass_sample_a, 32'h40);
		chk(bypass_sample_b, 32'h123);
		chk(mixed_a, 32'h0);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h41);
		adc_sample_b <= 12'h000;
		cyc(3);
		chk(bypass_sample_a, 32'h0);
		chk(bypass_sample_b, 32'h0);
		chk(mixed_a, 32'h04000000);
		chk(mixed_b, 32'h0);
		chk(mixed_valid_b, 32'h1);
		// Cross binding: A takes the silent channel B, B takes channel A
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h21);
		cyc(3);
		chk(mixed_b, 32'h04000000);
		chk(mixed_a, 32'h0);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h3);
		cyc(3);
		chk(mixed_valid_b, 32'h0);
		chk(mixed_b, 32'h0);
		// Quarter and half turn offsets on oscillators 1 and 2
		apb(1'h1, ddc_front_pkg::ADDR_PHASE_A + 8'h04, 32'h4000);
		apb(1'h1, ddc_front_pkg::ADDR_PHASE_A + 8'h08, 32'h8000);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h101);
		hop_pin_a_bit1 <= 1'h1;
		cyc(3);
		chk(mixed_a, 32'h0000FC00);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h105);
		cyc(5);
		chk(mixed_a, 32'hFC000000);
		// Half turn per cycle, then armed sysref
		apb(1'h1, ddc_front_pkg::ADDR_FREQ_A, 32'h80000000);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h11);
		rd(ddc_front_pkg::ADDR_STATUS, 32'h10);
		pulse_go <= 1'h1;
		@(posedge mclk);
		pulse_go <= 1'h0;
		@(posedge mclk iff sysref_in === 1'h1);
		cyc(2);
		chk(mixed_a, 32'h04000000);
		cyc(1);
		chk(mixed_a, 32'hFC000000);
		rd(ddc_front_pkg::ADDR_CTRL, 32'h1);
		rd(ddc_front_pkg::ADDR_STATUS, 32'h20);
		// Link sync release on oscillator 1
		apb(1'h1, ddc_front_pkg::ADDR_FREQ_A + 8'h04, 32'h80000000);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h109);
		sync_go <= 1'h1;
		@(posedge mclk iff link_sync_in === 1'h1);
		cyc(2);
		chk(mixed_a, 32'h0000FC00);
		cyc(1);
		chk(mixed_a, 32'h00000400);
		// Oscillator settings read back from converter A's slots
		rd(ddc_front_pkg::ADDR_FREQ_A + 8'h04, 32'h80000000);
		rd(ddc_front_pkg::ADDR_PHASE_A + 8'h04, 32'h4000);
		// Divider of one snaps phase every 64 cycles; half a table step per cycle
		apb(1'h1, ddc_front_pkg::ADDR_RDIV, 32'h1);
		rd(ddc_front_pkg::ADDR_RDIV, 32'h1);
		apb(1'h1, ddc_front_pkg::ADDR_FREQ_A, 32'h02000000);
		apb(1'h1, ddc_front_pkg::ADDR_CTRL, 32'h11);
		pulse_go <= 1'h1;
		@(posedge mclk);
		pulse_go <= 1'h0;
		@(posedge mclk iff sysref_in === 1'h1);
		// Without the snap the phase would be a half turn here
		cyc(66);
		chk(mixed_a, 32'h04000000);
		report_and_stop;
	end
endmodule
